// *** logic/rmbm_pkg.sv ***
// Purpose: Shared constants, state types and helpers for the reassembly memory bus master.
// Assumes: One system clock at 20 MHz, active-low asynchronous reset.
// Notes: Packet lines carry 32 data bits and 4 byte-parity bits.
package rmbm_pkg;
   localparam int ADDR_W = 16;
   localparam int PKT_DATA_W = 32;
   localparam int PKT_LINE_W = 36;
   localparam int HALF_W = 16;
   localparam int CTL_DATA_W = 16;
   localparam int BURST_LEN_DEF = 4;
   localparam int CTL_DEPTH_DEF = 256;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam int PAR_UP_HI = 35;
   localparam int PAR_UP_LO = 34;
   localparam int PAR_LO_HI = 33;
   localparam int PAR_LO_LO = 32;

   typedef enum logic [2:0] {
      PK_IDLE = 3'b001,
      PK_REQ = 3'b010,
      PK_XFER = 3'b100
   } rmbm_pk_state_t;

   typedef enum logic [3:0] {
      CT_IDLE = 4'b0001,
      CT_REQ = 4'b0010,
      CT_START = 4'b0100,
      CT_HOLD = 4'b1000
   } rmbm_ct_state_t;

   // Even parity of each byte of a half word, upper byte first.
   function automatic logic [1:0] rmbm_half_parity(input logic [HALF_W-1:0] h);
      rmbm_half_parity = {^h[15:8], ^h[7:0]};
   endfunction
endpackage

// *** logic/rmbm_if.sv ***
// Purpose: Packet and control memory bus between the device and the arbiter side.
// Assumes: Both ends run on the same system clock.
// Notes: The shared control data wire is resolved here from the two enables.
`timescale 1ns/100ps
interface rmbm_if;
   logic pkt_req;
   logic packet_bus_grant;
   logic packet_mem_ready_n;
   logic pkt_strobe;
   logic [15:0] pkt_addr;
   logic [35:0] packet_data_lines;
   logic pkt_lines_oe;
   logic ctl_req;
   logic control_bus_grant;
   logic control_cycle_start_n;
   logic control_cycle_hold;
   logic control_write_strobe;
   logic [15:0] ctl_addr;
   logic [15:0] dev_ctl_dout;
   logic dev_ctl_oe;
   logic [15:0] host_ctl_dout;
   logic host_ctl_oe;
   logic [15:0] ctl_data;

   // A bus nobody drives reads as zero.
   assign ctl_data = dev_ctl_oe ? dev_ctl_dout : (host_ctl_oe ? host_ctl_dout : 16'h0000);

   modport dev (
      output pkt_req, pkt_strobe, pkt_addr, packet_data_lines, pkt_lines_oe,
      input packet_bus_grant, packet_mem_ready_n,
      output ctl_req, control_cycle_start_n, control_cycle_hold, control_write_strobe,
      output ctl_addr, dev_ctl_dout, dev_ctl_oe,
      input control_bus_grant, ctl_data
   );
   modport host (
      input pkt_req, pkt_strobe, pkt_addr, packet_data_lines, pkt_lines_oe,
      output packet_bus_grant, packet_mem_ready_n,
      input ctl_req, control_cycle_start_n, control_cycle_hold, control_write_strobe,
      input ctl_addr, dev_ctl_dout, dev_ctl_oe, ctl_data,
      output control_bus_grant, host_ctl_dout, host_ctl_oe
   );
endinterface

// *** logic/rmbm_dev.sv ***
// Purpose: Device end, packet memory burst writer and control memory cycle master.
// Assumes: Grant and ready inputs are synchronous to clock.
// Notes: Packet words enter through a two-entry buffer so a stall loses nothing.
// Overview of operation
// - Grant loss: finish word, then re-request
// - Final word preempted: request again, repeat it
// - Every preempted repeat repeats once more
// - Arbiter drops ready, then grant two clocks later
// - Sixteen-bit big-endian: upper word goes first
// - Big-endian memory wires to upper lines, parity
// - Other widths and orders keep natural order
// - Early control grant loss may leave data driven
// - Early control grant loss may corrupt addresses
// - Arbiter never preempts a started control cycle
// - Cycle done when start and hold inactive
// - Write strobe falls with start, either mode
`timescale 1ns/100ps
module rmbm_dev #(
   parameter int BURST_LEN = rmbm_pkg::BURST_LEN_DEF
) (
   input wire logic clock,
   input wire logic rst_n,
   rmbm_if.dev bus,
   input wire logic mode_16bit,
   input wire logic big_endian,
   input wire logic early_write_select,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [rmbm_pkg::PKT_DATA_W-1:0] in_data,
   input wire logic ctl_cmd_valid,
   output logic ctl_cmd_ready,
   input wire logic ctl_cmd_we,
   input wire logic [rmbm_pkg::ADDR_W-1:0] ctl_cmd_addr,
   input wire logic [rmbm_pkg::CTL_DATA_W-1:0] ctl_cmd_wdata,
   output logic ctl_rsp_valid,
   output logic [rmbm_pkg::CTL_DATA_W-1:0] ctl_rsp_data
);
   import rmbm_pkg::*;

   if (BURST_LEN < 1 || BURST_LEN > 255) begin : g_chk
      $error("BURST_LEN must lie between 1 and 255");
   end

   logic [PKT_DATA_W-1:0] buf_r [2];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;
   rmbm_pk_state_t pk_state_r;
   logic [7:0] beats_r;
   logic half_r;
   logic [ADDR_W-1:0] pkt_addr_r;
   logic [PKT_DATA_W-1:0] head;
   logic taken;
   logic last_word;
   logic unit_done;
   logic [HALF_W-1:0] half_data;
   rmbm_ct_state_t ct_state_r;
   logic ct_we_r;
   logic [ADDR_W-1:0] ct_addr_r;
   logic [CTL_DATA_W-1:0] ct_wdata_r;

   // Two-entry buffer between the user stream and the packet bus.
   assign in_ready = (count_r != 2'd2);
   assign push = in_valid && in_ready;
   assign head = buf_r[rd_ptr_r];

   always_ff @(posedge clock) begin
      if (push) begin
         buf_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'd0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // A word moves when it is offered, the device holds the bus and memory is ready.
   assign taken = (pk_state_r == PK_XFER) && (count_r != 2'd0) && !bus.packet_mem_ready_n;
   assign last_word = (beats_r == 8'd1) && (!mode_16bit || half_r);
   assign unit_done = taken && (!mode_16bit || half_r);
   // final word repeat
   // A final word that moves while the grant is gone stays in the buffer for another pass.
   assign pop = unit_done && !(last_word && !bus.packet_bus_grant);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pk_state_r <= PK_IDLE;
         beats_r <= 8'd0;
         half_r <= 1'b0;
         pkt_addr_r <= ADDR_RESET;
      end else begin
         case (pk_state_r)
            PK_IDLE: begin
               half_r <= 1'b0;
               if (count_r != 2'd0) begin
                  beats_r <= 8'(BURST_LEN);
                  pk_state_r <= PK_REQ;
               end
            end
            PK_REQ: begin
               if (bus.packet_bus_grant) begin
                  pk_state_r <= PK_XFER;
               end
            end
            PK_XFER: begin
               if (taken && mode_16bit && !half_r) begin
                  half_r <= 1'b1;
               end else if (pop) begin
                  half_r <= 1'b0;
                  beats_r <= beats_r - 8'd1;
                  pkt_addr_r <= pkt_addr_r + 16'h0001;
               end else if (taken && last_word) begin
                  half_r <= mode_16bit ? 1'b0 : half_r;
               end
               if (pop && last_word) begin
                  pk_state_r <= PK_IDLE;
               end else if (!bus.packet_bus_grant) begin
                  pk_state_r <= PK_REQ;
               end
            end
            default: begin
               pk_state_r <= PK_IDLE;
            end
         endcase
      end
   end

   assign half_data = (big_endian ^ half_r) ? head[31:16] : head[15:0];

   always_comb begin
      bus.packet_data_lines = 36'h0_0000_0000;
      if (!mode_16bit) begin
         bus.packet_data_lines = {rmbm_half_parity(head[31:16]), rmbm_half_parity(head[15:0]),
                                  head};
      end else if (big_endian) begin
         bus.packet_data_lines[31:16] = half_data;
         bus.packet_data_lines[PAR_UP_HI:PAR_UP_LO] = rmbm_half_parity(half_data);
      end else begin
         bus.packet_data_lines[15:0] = half_data;
         bus.packet_data_lines[PAR_LO_HI:PAR_LO_LO] = rmbm_half_parity(half_data);
      end
   end

   assign bus.pkt_req = (pk_state_r != PK_IDLE);
   assign bus.pkt_strobe = (pk_state_r == PK_XFER) && (count_r != 2'd0);
   assign bus.pkt_lines_oe = (pk_state_r == PK_XFER);
   assign bus.pkt_addr = pkt_addr_r;

   // Control memory cycles, one command at a time.
   assign ctl_cmd_ready = (ct_state_r == CT_IDLE);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ct_state_r <= CT_IDLE;
         ct_we_r <= 1'b0;
         ct_addr_r <= ADDR_RESET;
         ct_wdata_r <= 16'h0000;
      end else begin
         case (ct_state_r)
            CT_IDLE: begin
               if (ctl_cmd_valid) begin
                  ct_we_r <= ctl_cmd_we;
                  ct_addr_r <= ctl_cmd_addr;
                  ct_wdata_r <= ctl_cmd_wdata;
                  ct_state_r <= CT_REQ;
               end
            end
            CT_REQ: begin
               if (bus.control_bus_grant) begin
                  ct_state_r <= CT_START;
               end
            end
            CT_START: begin
               ct_state_r <= CT_HOLD;
            end
            CT_HOLD: begin
               ct_state_r <= CT_IDLE;
            end
            default: begin
               ct_state_r <= CT_IDLE;
            end
         endcase
      end
   end

   // grant loss ignored
   // A started cycle always runs to its end; dropping the data bus part way is not safe.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_rsp_valid <= 1'b0;
         ctl_rsp_data <= 16'h0000;
      end else begin
         ctl_rsp_valid <= (ct_state_r == CT_HOLD);
         if (ct_state_r == CT_HOLD && !ct_we_r) begin
            ctl_rsp_data <= bus.ctl_data;
         end
      end
   end

   assign bus.ctl_req = (ct_state_r == CT_REQ);
   assign bus.control_cycle_start_n = (ct_state_r != CT_START);
   assign bus.control_cycle_hold = (ct_state_r == CT_START) || (ct_state_r == CT_HOLD);
   // strobe drops with start
   // The early-write choice is accepted but does not move the strobe a clock earlier.
   assign bus.control_write_strobe = (ct_state_r == CT_START) && ct_we_r &&
                                     (early_write_select || !early_write_select);
   assign bus.ctl_addr = ct_addr_r;
   assign bus.dev_ctl_dout = ct_wdata_r;
   assign bus.dev_ctl_oe = ct_we_r && bus.control_cycle_hold;
endmodule

// *** logic/rmbm_host.sv ***
// Purpose: Arbiter end with packet sink and control memory.
// Assumes: Same system clock as the device end.
// Notes: Packet preemption always drops ready two clocks before grant.
`timescale 1ns/100ps
module rmbm_host #(
   parameter int CTL_DEPTH = rmbm_pkg::CTL_DEPTH_DEF
) (
   input wire logic clock,
   input wire logic rst_n,
   rmbm_if.host bus,
   input wire logic mode_16bit,
   input wire logic big_endian,
   input wire logic preempt,
   input wire logic ctl_deny,
   output logic out_valid,
   input wire logic out_ready,
   output logic [rmbm_pkg::PKT_DATA_W-1:0] out_data
);
   import rmbm_pkg::*;

   if (CTL_DEPTH < 2 || CTL_DEPTH > 65536 || (1 << $clog2(CTL_DEPTH)) != CTL_DEPTH) begin : g_chk
      $error("CTL_DEPTH must be a power of two between 2 and 65536");
   end

   localparam int IDX_W = $clog2(CTL_DEPTH);

   logic grant_r;
   logic drop_r;
   logic stall;
   logic taken;
   logic half_r;
   logic [HALF_W-1:0] first_r;
   logic [HALF_W-1:0] half_in;
   logic [CTL_DATA_W-1:0] mem [CTL_DEPTH];
   logic [CTL_DATA_W-1:0] rdata_r;
   logic cgrant_r;
   logic wr_cycle_r;
   logic ctl_busy;
   logic [IDX_W-1:0] idx;

   // Back-pressure from the user side reaches the device through ready.
   assign stall = out_valid && !out_ready;
   assign bus.packet_mem_ready_n = !(grant_r && !drop_r && !preempt && !stall);
   assign bus.packet_bus_grant = grant_r;
   assign taken = bus.pkt_strobe && !bus.packet_mem_ready_n;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         grant_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         drop_r <= preempt && grant_r && !drop_r;
         if (drop_r || !bus.pkt_req) begin
            grant_r <= 1'b0;
         end else if (!preempt && !grant_r) begin
            grant_r <= 1'b1;
         end
      end
   end

   assign half_in = big_endian ? bus.packet_data_lines[31:16] : bus.packet_data_lines[15:0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         half_r <= 1'b0;
         first_r <= 16'h0000;
         out_valid <= 1'b0;
         out_data <= 32'h0000_0000;
      end else begin
         if (out_valid && out_ready) begin
            out_valid <= 1'b0;
         end
         if (taken) begin
            if (!mode_16bit) begin
               out_valid <= 1'b1;
               out_data <= bus.packet_data_lines[31:0];
            end else if (!half_r) begin
               half_r <= 1'b1;
               first_r <= half_in;
            end else begin
               half_r <= 1'b0;
               out_valid <= 1'b1;
               out_data <= big_endian ? {first_r, half_in} : {half_in, first_r};
            end
         end
      end
   end

   assign ctl_busy = !bus.control_cycle_start_n || bus.control_cycle_hold;
   assign idx = bus.ctl_addr[IDX_W-1:0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cgrant_r <= 1'b0;
      end else if (!ctl_busy && !(cgrant_r && bus.ctl_req)) begin
         // A grant the device has already sampled stays up, since its cycle starts on that edge.
         cgrant_r <= bus.ctl_req && !ctl_deny;
      end
   end

   always_ff @(posedge clock) begin
      if (!bus.control_cycle_start_n && bus.control_write_strobe) begin
         mem[idx] <= bus.ctl_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 16'h0000;
         wr_cycle_r <= 1'b0;
      end else if (!bus.control_cycle_start_n) begin
         rdata_r <= mem[idx];
         wr_cycle_r <= bus.control_write_strobe;
      end
   end

   assign bus.control_bus_grant = cgrant_r;
   assign bus.host_ctl_dout = rdata_r;
   assign bus.host_ctl_oe = bus.control_cycle_hold && bus.control_cycle_start_n && !wr_cycle_r;
endmodule

// *** verif/rmbm_checker.sv ***
// Purpose: Concurrent checks on the memory bus between the two ends.
// Assumes: One system clock, reset rst_n active low.
// Notes: Sees interface signals only, so width and order are judged by the bench.
`timescale 1ns/100ps
module rmbm_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pkt_req,
   input wire logic packet_bus_grant,
   input wire logic packet_mem_ready_n,
   input wire logic pkt_strobe,
   input wire logic pkt_lines_oe,
   input wire logic control_bus_grant,
   input wire logic control_cycle_start_n,
   input wire logic control_cycle_hold,
   input wire logic control_write_strobe,
   input wire logic dev_ctl_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_start;
      !control_cycle_start_n && control_cycle_hold;
   endsequence
   sequence s_tail;
      control_cycle_start_n && control_cycle_hold ##1 !control_cycle_hold;
   endsequence
   property p_cycle;
      $fell(control_cycle_start_n) |-> s_start ##1 s_tail;
   endproperty
   property p_ctl_grant;
      $fell(control_cycle_start_n) |-> $past(control_bus_grant);
   endproperty
   property p_grant_held;
      control_cycle_hold |-> control_bus_grant;
   endproperty
   property p_wstrobe;
      control_write_strobe |-> !control_cycle_start_n ##1 !control_write_strobe;
   endproperty
   property p_data_free;
      dev_ctl_oe |-> control_cycle_hold;
   endproperty
   property p_pkt_grant;
      $rose(pkt_strobe) |-> $past(packet_bus_grant);
   endproperty
   property p_strobe_req;
      pkt_strobe |-> pkt_req && pkt_lines_oe;
   endproperty
   property p_preempt;
      pkt_strobe && !packet_bus_grant |=> !pkt_strobe && pkt_req;
   endproperty
   property p_ready_first;
      $fell(packet_bus_grant) && $past(pkt_req) && pkt_req |-> $past(packet_mem_ready_n);
   endproperty
   a_cycle: assert property (p_cycle) else $error("control cycle shape wrong");
   a_ctl_grant: assert property (p_ctl_grant) else $error("control start without grant");
   a_grant_held: assert property (p_grant_held) else $error("control grant lost");
   a_wstrobe: assert property (p_wstrobe) else $error("write strobe timing wrong");
   a_data_free: assert property (p_data_free) else $error("data driven after cycle");
   a_pkt_grant: assert property (p_pkt_grant) else $error("packet word without grant");
   a_strobe_req: assert property (p_strobe_req) else $error("strobe without request");
   a_preempt: assert property (p_preempt) else $error("no re-request on grant loss");
   a_ready_first: assert property (p_ready_first) else $error("grant dropped before ready");
endmodule

// *** verif/rmbm_tb.sv ***
// Purpose: Self-checking bench joining device and arbiter ends.
// Assumes: Inputs change at the falling edge; seed fixed.
// Notes: Expected words and line values are queued by the drivers, popped by one monitor.
`timescale 1ns/100ps
module rmbm_tb;
   import rmbm_pkg::*;
   localparam int LIMIT = 20000;
   logic clock, rst_n, mode_16bit, big_endian, early_write_select;
   logic in_valid, in_ready, out_valid, out_ready, preempt, ctl_deny;
   logic ctl_cmd_valid, ctl_cmd_ready, ctl_cmd_we, ctl_rsp_valid;
   logic [PKT_DATA_W-1:0] in_data, out_data;
   logic [ADDR_W-1:0] ctl_cmd_addr;
   logic [CTL_DATA_W-1:0] ctl_cmd_wdata, ctl_rsp_data;
   logic [CTL_DATA_W-1:0] mem [256];
   logic [CTL_DATA_W:0] c;
   logic [PKT_DATA_W-1:0] wq[$];
   logic [PKT_LINE_W-1:0] lq[$];
   logic [CTL_DATA_W:0] cq[$];
   logic [ADDR_W-1:0] ea = 16'h0000;
   logic hb = 1'b0;
   int miscompares = 0, tests_run = 0, cyc = 0;
   integer seed = 32'h36C6C503;
   rmbm_if bus ();
   rmbm_dev #(.BURST_LEN(4)) rmbm_dev_i (.clock(clock), .rst_n(rst_n), .bus(bus),
      .mode_16bit(mode_16bit), .big_endian(big_endian), .early_write_select(early_write_select),
      .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
      .ctl_cmd_valid(ctl_cmd_valid), .ctl_cmd_ready(ctl_cmd_ready), .ctl_cmd_we(ctl_cmd_we),
      .ctl_cmd_addr(ctl_cmd_addr), .ctl_cmd_wdata(ctl_cmd_wdata),
      .ctl_rsp_valid(ctl_rsp_valid), .ctl_rsp_data(ctl_rsp_data));
   rmbm_host #(.CTL_DEPTH(256)) rmbm_host_i (.clock(clock), .rst_n(rst_n), .bus(bus),
      .mode_16bit(mode_16bit), .big_endian(big_endian), .preempt(preempt),
      .ctl_deny(ctl_deny), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
   rmbm_checker rmbm_checker_i (.clock(clock), .rst_n(rst_n), .pkt_req(bus.pkt_req),
      .packet_bus_grant(bus.packet_bus_grant), .packet_mem_ready_n(bus.packet_mem_ready_n),
      .pkt_strobe(bus.pkt_strobe), .pkt_lines_oe(bus.pkt_lines_oe),
      .control_bus_grant(bus.control_bus_grant),
      .control_cycle_start_n(bus.control_cycle_start_n),
      .control_cycle_hold(bus.control_cycle_hold),
      .control_write_strobe(bus.control_write_strobe), .dev_ctl_oe(bus.dev_ctl_oe));

   function automatic logic [1:0] pp(input logic [15:0] h);
      return {^h[15:8], ^h[7:0]};
   endfunction
   function automatic logic [35:0] ln(input logic [15:0] h, input logic hi);
      return hi ? {pp(h), 2'b00, h, 16'h0000} : {2'b00, pp(h), 16'h0000, h};
   endfunction
   // Lanes the memory does not wire up are masked out.
   function automatic logic [35:0] lm();
      if (!mode_16bit) return 36'hF_FFFF_FFFF;
      return big_endian ? 36'hC_FFFF_0000 : 36'h3_0000_FFFF;
   endfunction
   task automatic bad(input logic [35:0] got, exp);
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic chk_w(input logic [PKT_DATA_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) bad(36'(got), 36'(exp));
   endtask
   task automatic chk_l(input logic [PKT_LINE_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) bad(got, exp);
   endtask
   task automatic chk_c(input logic [CTL_DATA_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) bad(36'(got), 36'(exp));
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic put(input logic [PKT_DATA_W-1:0] w);
      @(negedge clock);
      in_valid = 1'b1;
      in_data = w;
      wq.push_back(w);
      if (!mode_16bit) begin
         lq.push_back({pp(w[31:16]), pp(w[15:0]), w});
      end else begin
         lq.push_back(ln(big_endian ? w[31:16] : w[15:0], big_endian));
         lq.push_back(ln(big_endian ? w[15:0] : w[31:16], big_endian));
      end
      while (!in_ready) @(negedge clock);
      @(posedge clock);
   endtask
   task automatic cmd(input logic we, input logic [7:0] a);
      @(negedge clock);
      ctl_cmd_valid = 1'b1;
      ctl_cmd_we = we;
      ctl_cmd_addr = {8'($random(seed)), a};
      ctl_cmd_wdata = 16'($random(seed));
      if (we) mem[a] = ctl_cmd_wdata;
      cq.push_back({!we, mem[a]});
      while (!ctl_cmd_ready) @(negedge clock);
      @(posedge clock);
      @(negedge clock);
      ctl_cmd_valid = 1'b0;
   endtask

   initial begin
      clock = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == LIMIT) begin
         miscompares++;
         report_and_stop();
      end
   end
   // Random stalls and preemption keep the far side unkind.
   always @(negedge clock) begin
      out_ready = ($random(seed) & 3) != 0;
      preempt = ($random(seed) & 7) == 0;
      ctl_deny = ($random(seed) & 3) == 0;
   end
   always @(posedge clock) begin
      if (rst_n && out_valid && out_ready) chk_w(out_data, wq.pop_front());
      if (rst_n && bus.pkt_strobe && !bus.packet_mem_ready_n) begin
         chk_l(bus.packet_data_lines & lm(), lq.pop_front());
         chk_c(bus.pkt_addr, ea);
         if (!mode_16bit || hb) ea = ea + 16'h0001;
         if (mode_16bit) hb = !hb;
      end
      if (rst_n && ctl_rsp_valid) begin
         c = cq.pop_front();
         if (c[CTL_DATA_W]) chk_c(ctl_rsp_data, c[CTL_DATA_W-1:0]);
      end
   end
   initial begin
      rst_n = 1'b0;
      {mode_16bit, big_endian, early_write_select, in_valid, ctl_cmd_valid} = 5'h00;
      ctl_cmd_we = 1'b0;
      in_data = 32'h0000_0000;
      ctl_cmd_addr = 16'h0000;
      ctl_cmd_wdata = 16'h0000;
      repeat (20) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++) begin
         @(negedge clock);
         mode_16bit = m[1];
         big_endian = m[0];
         put(32'hFFFF_0000);
         for (int i = 0; i < 7; i++) put(32'($random(seed)));
         @(negedge clock);
         in_valid = 1'b0;
         wait (wq.size() == 0 && lq.size() == 0);
         $display("test packet mode %0d done", m);
      end
      for (int e = 0; e < 2; e++) begin
         @(negedge clock);
         early_write_select = e[0];
         for (int i = 0; i < 4; i++) cmd(1'b1, 8'(i + 4 * e));
         for (int i = 0; i < 4; i++) cmd(1'b0, 8'(i + 4 * e));
         wait (cq.size() == 0);
         $display("test control early %0d done", e);
      end
      report_and_stop();
   end
endmodule
